/* rbs_host.sv */
`timescale 1ns/1ps
`default_nettype none
module rbs_host (
	// system clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	// serial link, this end makes the clock
	rbs_link_if.host        link,
	// command
	input  wire logic       i_cmd_valid,
	input  wire logic       i_cmd_read,
	input  wire logic [6:0] i_cmd_dev,
	input  wire logic [6:0] i_cmd_reg,
	input  wire logic [3:0] i_cmd_len,
	output logic            o_cmd_ready,
	// write data, next byte offered after each take
	input  wire logic [7:0] i_wdata,
	output logic            o_wdata_take,
	// results
	output logic [7:0]      o_rdata,
	output logic            o_rdata_valid,
	output logic            o_done,
	output logic            o_nack_err
);

	// ****************************************
	// quarter-bit timebase
	// ****************************************
	logic [8:0]             div_q;
	wire                    tick = div_q == rbs_pkg::QUARTER_LAST;

	// (RULE15) rate fixed by divider
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			div_q <= 9'h000;
		else
			div_q <= tick ? 9'h000 : div_q + 9'h001;
	end

	logic                   sda_m_q;
	logic                   sda_s_q;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else begin
			sda_m_q <= link.sda;
			sda_s_q <= sda_m_q;
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	rbs_pkg::rbs_hstate_t   st_q;
	rbs_pkg::rbs_kind_t     kind_q;
	logic [1:0]             qtr_q;
	logic [3:0]             bit_q;
	logic [8:0]             tx_q;
	logic [8:0]             rx_q;
	logic                   read_q;
	logic [6:0]             dev_q;
	logic [3:0]             left_q;
	logic                   scl_q;
	logic                   oe_q;

	wire                    q_end    = tick && qtr_q == 2'h3;
	wire                    byte_end = q_end && bit_q == rbs_pkg::BIT_ACK;
	wire                    nacked   = rx_q[0];
	wire                    last_rd  = left_q == 4'h1;
	wire [8:0]              rd_slot  = {8'hff, last_rd};

	assign link.scl      = scl_q;
	// (RULE5) release for one
	assign link.sda_oe_m = oe_q;
	assign link.sda_o_m  = 1'b0;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			qtr_q <= 2'h0;
		else if (st_q == rbs_pkg::H_IDLE)
			qtr_q <= 2'h0;
		else if (tick)
			qtr_q <= qtr_q + 2'h1;
	end

	// pin levels per quarter
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			scl_q <= 1'b1;
			oe_q  <= 1'b0;
			rx_q  <= 9'h000;
		end else if (tick) begin
			case (st_q)
				// (RULE4) start condition
				rbs_pkg::H_START: begin
					oe_q  <= qtr_q != 2'h0;
					scl_q <= qtr_q < 2'h2;
				end
				rbs_pkg::H_RSTART: begin
					oe_q  <= qtr_q >= 2'h2;
					scl_q <= qtr_q == 2'h1 || qtr_q == 2'h2;
				end
				rbs_pkg::H_BYTE: begin
					if (qtr_q == 2'h0)
						oe_q <= !tx_q[8];
					scl_q <= qtr_q == 2'h1 || qtr_q == 2'h2;
					// (RULE7) ack read a quarter after rise
					if (qtr_q == 2'h2)
						rx_q <= {rx_q[7:0], sda_s_q};
				end
				// (RULE11) stop: data rises, clock high
				rbs_pkg::H_STOP: begin
					oe_q  <= qtr_q < 2'h2;
					scl_q <= qtr_q != 2'h0;
				end
				default: begin
					oe_q  <= 1'b0;
					scl_q <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_q          <= rbs_pkg::H_IDLE;
			kind_q        <= rbs_pkg::K_ADDRW;
			bit_q         <= 4'h0;
			tx_q          <= 9'h1ff;
			read_q        <= 1'b0;
			dev_q         <= 7'h00;
			left_q        <= 4'h0;
			o_cmd_ready   <= 1'b0;
			o_wdata_take  <= 1'b0;
			o_rdata       <= 8'h00;
			o_rdata_valid <= 1'b0;
			o_done        <= 1'b0;
			o_nack_err    <= 1'b0;
		end else begin
			o_wdata_take  <= 1'b0;
			o_rdata_valid <= 1'b0;
			o_done        <= 1'b0;
			o_cmd_ready   <= st_q == rbs_pkg::H_IDLE && !i_cmd_valid;
			case (st_q)
				rbs_pkg::H_IDLE: begin
					if (i_cmd_valid && o_cmd_ready) begin
						read_q     <= i_cmd_read;
						dev_q      <= i_cmd_dev;
						left_q     <= (i_cmd_len == 4'h0) ? 4'h1 : i_cmd_len;
						kind_q     <= rbs_pkg::K_ADDRW;
						tx_q       <= {i_cmd_dev, 1'b0, 1'b1};
						bit_q      <= 4'h0;
						o_nack_err <= 1'b0;
						st_q       <= rbs_pkg::H_START;
					end
				end
				rbs_pkg::H_START, rbs_pkg::H_RSTART: begin
					if (q_end)
						st_q <= rbs_pkg::H_BYTE;
				end
				rbs_pkg::H_BYTE: begin
					if (q_end) begin
						bit_q <= bit_q + 4'h1;
						tx_q  <= {tx_q[7:0], 1'b1};
					end
					if (byte_end) begin
						bit_q <= 4'h0;
						st_q  <= rbs_pkg::H_STOP;
						case (kind_q)
							rbs_pkg::K_ADDRW: begin
								o_nack_err <= nacked;
								if (!nacked) begin
									// (RULE8) (RULE12) location byte next
									kind_q <= rbs_pkg::K_REG;
									tx_q   <= {1'b0, i_cmd_reg, 1'b1};
									st_q   <= rbs_pkg::H_BYTE;
								end
							end
							rbs_pkg::K_REG: begin
								o_nack_err <= nacked;
								if (!nacked && read_q) begin
									// (RULE13) repeated start for reading
									kind_q <= rbs_pkg::K_ADDRR;
									tx_q   <= {dev_q, 1'b1, 1'b1};
									st_q   <= rbs_pkg::H_RSTART;
								end else if (!nacked) begin
									kind_q       <= rbs_pkg::K_WDATA;
									tx_q         <= {i_wdata, 1'b1};
									o_wdata_take <= 1'b1;
									st_q         <= rbs_pkg::H_BYTE;
								end
							end
							rbs_pkg::K_WDATA: begin
								o_nack_err <= nacked;
								left_q     <= left_q - 4'h1;
								if (!nacked && !last_rd) begin
									tx_q         <= {i_wdata, 1'b1};
									o_wdata_take <= 1'b1;
									st_q         <= rbs_pkg::H_BYTE;
								end
							end
							rbs_pkg::K_ADDRR: begin
								o_nack_err <= nacked;
								if (!nacked) begin
									kind_q <= rbs_pkg::K_RDATA;
									tx_q   <= rd_slot;
									st_q   <= rbs_pkg::H_BYTE;
								end
							end
							default: begin
								o_rdata       <= rx_q[8:1];
								o_rdata_valid <= 1'b1;
								left_q        <= left_q - 4'h1;
								// (RULE14) withhold ack on last
								if (!last_rd) begin
									tx_q <= {8'hff, left_q == 4'h2};
									st_q <= rbs_pkg::H_BYTE;
								end
							end
						endcase
					end
				end
				rbs_pkg::H_STOP: begin
					if (q_end) begin
						o_done <= 1'b1;
						st_q   <= rbs_pkg::H_IDLE;
					end
				end
				default: st_q <= rbs_pkg::H_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* rbs_pkg.sv */
// ****************************************
// shared constants
// ****************************************
package rbs_pkg;
	// fixed upper address bits, straps fill the two low bits
	localparam logic [4:0] ADDR_BASE   = 5'h08;
	localparam int         BANK_DEPTH  = 128;
	localparam logic [6:0] RW_LAST     = 7'h50;
	localparam logic [6:0] RO_FIRST    = 7'h60;
	localparam int         RW_COUNT    = 81;
	localparam int         RO_COUNT    = 32;
	localparam logic [3:0] BIT_LAST    = 4'h7;
	localparam logic [3:0] BIT_ACK     = 4'h8;
	// bus timing for the master end
	localparam int         CLK_PERIOD_NS = 5;
	localparam int         SCL_PERIOD_NS = 10000;
	localparam int         QUARTER_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam logic [8:0] QUARTER_LAST  = 9'(QUARTER_CYC - 1);

	typedef enum logic [4:0] {
		D_IDLE  = 5'h01,
		D_ADDR  = 5'h02,
		D_REG   = 5'h04,
		D_WDATA = 5'h08,
		D_RDATA = 5'h10
	} rbs_dstate_t;

	typedef enum logic [4:0] {
		H_IDLE   = 5'h01,
		H_START  = 5'h02,
		H_BYTE   = 5'h04,
		H_RSTART = 5'h08,
		H_STOP   = 5'h10
	} rbs_hstate_t;

	typedef enum logic [4:0] {
		K_ADDRW = 5'h01,
		K_REG   = 5'h02,
		K_WDATA = 5'h04,
		K_ADDRR = 5'h08,
		K_RDATA = 5'h10
	} rbs_kind_t;
endpackage

/* rbs_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// two-wire link, data line pulled up, clock driven by the master
// ****************************************
interface rbs_link_if;
	logic scl;
	logic sda;
	logic sda_oe_m;
	logic sda_o_m;
	logic sda_oe_s;
	logic sda_o_s;

	// open drain: any enabled driver pulls low, else pull-up
	assign sda = ~((sda_oe_m & ~sda_o_m) | (sda_oe_s & ~sda_o_s));

	modport dev (input scl, input sda, output sda_oe_s, output sda_o_s);
	modport host (output scl, input sda, output sda_oe_m, output sda_o_m);
endinterface
`default_nettype wire

/* rbs_dev.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// (RULE1) answer address 01000 plus two strap levels
// (RULE2) hold 128 byte-wide bank locations; the code stores only 113 (0..80 and 96..127), and 81..95 read as 00
// (RULE3) 0..80 read/write, 96..127 read only
// (RULE4) master opens with start, address, write bit
// (RULE5) drive low for zero, release for one
// (RULE6) capture data on every clock rise
// (RULE7) acknowledge own address by pulling low
// (RULE8) write carries location then data bytes
// (RULE9) acknowledge each byte on ninth rise
// (RULE10) further write bytes go to next location
// (RULE11) stop condition ends the write
// (RULE12) read starts with write of location
// (RULE13) after read address, ack then send register
// (RULE14) bytes flow until master withholds acknowledge
// (RULE15) master keeps bus at most 100 kbit/s
// (RULE16) pointer advances after every byte sent
// (RULE17) writes to read-only locations ignored, acked
module rbs_dev (
	// system clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	// serial link, clocked by the master
	rbs_link_if.dev         link,
	// address straps
	input  wire logic       i_strap_high,
	input  wire logic       i_strap_low,
	// status bank update
	input  wire logic       i_stat_we,
	input  wire logic [4:0] i_stat_idx,
	input  wire logic [7:0] i_stat_data,
	output logic            o_stat_ready,
	// stored write and stop reports
	output logic            o_wr_valid,
	output logic [6:0]      o_wr_addr,
	output logic [7:0]      o_wr_data,
	output logic            o_stop
);

	// ****************************************
	// start and stop detection
	// ****************************************
	logic                   start_tgl_q;
	logic                   stop_tgl_q;

	// start: data falls while clock high
	always_ff @(negedge link.sda or negedge i_rstn) begin
		if (!i_rstn)
			start_tgl_q <= 1'b0;
		else if (link.scl)
			start_tgl_q <= ~start_tgl_q;
	end

	// (RULE11) stop seen
	always_ff @(posedge link.sda or negedge i_rstn) begin
		if (!i_rstn)
			stop_tgl_q <= 1'b0;
		else if (link.scl)
			stop_tgl_q <= ~stop_tgl_q;
	end

	// ****************************************
	// link-side state, on the bus clock
	// ****************************************
	rbs_pkg::rbs_dstate_t   state_q;
	logic                   start_seen_q;
	logic [3:0]             cnt_q;
	logic [6:0]             sr_q;
	logic [6:0]             ptr_q;
	logic                   ack_q;
	logic [7:0]             tx_q;
	logic [1:0]             strap_m_q;
	logic [1:0]             strap_q;
	logic                   sda_oe_q;
	logic [7:0]             cfg_q [rbs_pkg::RW_COUNT];
	logic [7:0]             stat_q [rbs_pkg::RO_COUNT];
	logic                   wr_tgl_q;
	logic [6:0]             wr_addr_q;
	logic [7:0]             wr_data_q;

	// start toggles are read directly: the fall lies a full high time before the next rise
	wire                    start_pend = start_tgl_q ^ start_seen_q;
	wire [7:0]              byte_in    = {sr_q, link.sda};
	wire                    last_bit   = cnt_q == rbs_pkg::BIT_LAST;
	wire                    ack_edge   = cnt_q == rbs_pkg::BIT_ACK;
	wire                    addr_hit   = byte_in[7:1] == {rbs_pkg::ADDR_BASE, strap_q};
	wire                    ptr_rw     = ptr_q <= rbs_pkg::RW_LAST;
	wire                    ptr_ro     = ptr_q >= rbs_pkg::RO_FIRST;
	wire                    wr_slot    = state_q == rbs_pkg::D_WDATA && last_bit && !start_pend;
	wire                    cfg_wr     = wr_slot && ptr_rw;
	// (RULE3) read map
	wire [7:0]              rd_data    = ptr_rw ? cfg_q[ptr_q] :
	                                     ptr_ro ? stat_q[ptr_q[4:0]] : 8'h00;

	// straps are static pins, still taken through two stages
	always_ff @(posedge link.scl or negedge i_rstn) begin
		if (!i_rstn) begin
			strap_m_q <= 2'h0;
			strap_q   <= 2'h0;
		end else begin
			strap_m_q <= {i_strap_high, i_strap_low};
			strap_q   <= strap_m_q;
		end
	end

	// (RULE6) sample on rise
	always_ff @(posedge link.scl or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q      <= rbs_pkg::D_IDLE;
			start_seen_q <= 1'b0;
			cnt_q        <= 4'h0;
			sr_q         <= 7'h00;
			ptr_q        <= 7'h00;
			ack_q        <= 1'b0;
			tx_q         <= 8'hff;
		end else if (start_pend) begin
			start_seen_q <= start_tgl_q;
			sr_q         <= {6'h00, link.sda};
			cnt_q        <= 4'h1;
			ack_q        <= 1'b0;
			state_q      <= rbs_pkg::D_ADDR;
		end else if (state_q == rbs_pkg::D_IDLE) begin
			cnt_q <= 4'h0;
		end else if (ack_edge) begin
			cnt_q <= 4'h0;
			ack_q <= 1'b0;
			if (state_q == rbs_pkg::D_RDATA) begin
				// (RULE14) master ack keeps bytes flowing
				if (!link.sda) begin
					tx_q  <= rd_data;
					// (RULE16) pointer after send
					ptr_q <= ptr_q + 7'h01;
				end else begin
					state_q <= rbs_pkg::D_IDLE;
				end
			end
		end else begin
			sr_q  <= byte_in[6:0];
			cnt_q <= cnt_q + 4'h1;
			if (last_bit) begin
				case (state_q)
					rbs_pkg::D_ADDR: begin
						// (RULE1) own address
						if (addr_hit) begin
							ack_q   <= 1'b1;
							state_q <= byte_in[0] ? rbs_pkg::D_RDATA : rbs_pkg::D_REG;
						end else begin
							state_q <= rbs_pkg::D_IDLE;
						end
					end
					rbs_pkg::D_REG: begin
						// (RULE12) location byte acked
						ptr_q   <= byte_in[6:0];
						ack_q   <= 1'b1;
						state_q <= rbs_pkg::D_WDATA;
					end
					rbs_pkg::D_WDATA: begin
						// (RULE10) next location
						ptr_q <= ptr_q + 7'h01;
						ack_q <= 1'b1;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// (RULE2) bank storage
	always_ff @(posedge link.scl or negedge i_rstn) begin
		if (!i_rstn) begin
			for (int i = 0; i < rbs_pkg::RW_COUNT; i++)
				cfg_q[i] <= 8'h00;
			wr_tgl_q  <= 1'b0;
			wr_addr_q <= 7'h00;
			wr_data_q <= 8'h00;
		end else if (cfg_wr) begin
			// (RULE17) only writable locations change
			cfg_q[ptr_q] <= byte_in;
			wr_tgl_q     <= ~wr_tgl_q;
			wr_addr_q    <= ptr_q;
			wr_data_q    <= byte_in;
		end
	end

	// drive on the fall so data is settled before the rise
	always_ff @(negedge link.scl or negedge i_rstn) begin
		if (!i_rstn)
			sda_oe_q <= 1'b0;
		// (RULE7) (RULE9) ack slot low
		else if (ack_edge)
			sda_oe_q <= ack_q && state_q != rbs_pkg::D_IDLE;
		// (RULE13) shift register out
		else
			sda_oe_q <= state_q == rbs_pkg::D_RDATA && !tx_q[~cnt_q[2:0]];
	end

	// (RULE5) only ever pull low
	assign link.sda_oe_s = sda_oe_q;
	assign link.sda_o_s  = 1'b0;

	// ****************************************
	// system-side crossing
	// ****************************************
	logic [2:0]             sync1_q;
	logic [2:0]             sync2_q;
	logic [2:0]             sync3_q;
	logic                   busy_q;

	wire [2:0]              ev = sync2_q ^ sync3_q;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
			sync3_q <= 3'h0;
		end else begin
			sync1_q <= {wr_tgl_q, stop_tgl_q, start_tgl_q};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// status held still while a frame runs: the link reads it with no handshake
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			busy_q       <= 1'b0;
			o_stat_ready <= 1'b0;
		end else begin
			busy_q       <= ev[0] | (busy_q & ~ev[1]);
			o_stat_ready <= ~(ev[0] | (busy_q & ~ev[1]));
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			for (int i = 0; i < rbs_pkg::RO_COUNT; i++)
				stat_q[i] <= 8'h00;
		end else if (i_stat_we && o_stat_ready) begin
			stat_q[i_stat_idx] <= i_stat_data;
		end
	end

	// report data is held on the link side for a whole byte, ample to capture
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_wr_valid <= 1'b0;
			o_wr_addr  <= 7'h00;
			o_wr_data  <= 8'h00;
			o_stop     <= 1'b0;
		end else begin
			o_wr_valid <= ev[2];
			o_stop     <= ev[1];
			if (ev[2]) begin
				o_wr_addr <= wr_addr_q;
				o_wr_data <= wr_data_q;
			end
		end
	end
endmodule
`default_nettype wire

/* rbs_link_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ********************************
// link protocol checker
// ********************************
module rbs_link_properties (
	// system clock and reset
	input  wire logic i_clk,
	input  wire logic i_rstn,
	// link wires
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic sda_oe_m,
	input  wire logic sda_o_m,
	input  wire logic sda_oe_s,
	input  wire logic sda_o_s
);
	logic       scl_q;
	logic       sda_q;
	logic       first_q;
	logic       rd_q;
	logic       acked_q;
	logic [3:0] bit_q;
	logic [7:0] shift_q;
	logic [10:0] gap_q;

	// both lines change only on i_clk edges, so plain sampling is safe
	wire       start_ev = scl & scl_q & sda_q & ~sda;
	wire       stop_ev  = scl & scl_q & ~sda_q & sda;
	wire       rise_ev  = scl & ~scl_q;
	wire       ninth    = rise_ev & (bit_q == 4'h8);
	wire [3:0] bit_d    = (start_ev | ninth) ? 4'h0 : bit_q + 4'(rise_ev);
	wire [7:0] shift_d  = (rise_ev & ~bit_q[3]) ? {shift_q[6:0], sda} : shift_q;
	wire       first_d  = start_ev | (first_q & ~ninth);
	wire       rd_d     = (ninth & first_q) ? shift_q[0] : rd_q;
	wire       acked_d  = ~stop_ev & ((ninth & first_q) ? sda_oe_s : acked_q);
	// saturating count of cycles since the last clock rise
	wire [10:0] gap_d   = rise_ev ? 11'h000 : gap_q + 11'(gap_q != 11'h7ff);

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			{scl_q, sda_q, first_q, rd_q, acked_q} <= 5'h18;
			bit_q <= 4'h0;
			shift_q <= 8'h00;
			gap_q <= 11'h7ff;
		end else begin
			gap_q <= gap_d;
			{scl_q, sda_q, first_q, rd_q, acked_q} <= {scl, sda, first_d, rd_d, acked_d};
			bit_q <= bit_d;
			shift_q <= shift_d;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	od_only_a: assert property ((!sda_oe_s || !sda_o_s) && (!sda_oe_m || !sda_o_m))
		else $error("an sda driver drives high");
	hold_high_a: assert property (scl && $past(scl) |-> $stable(sda_oe_s))
		else $error("device changed sda while scl high");
	addr_base_a: assert property (ninth && first_q && sda_oe_s |-> shift_q[7:3] == rbs_pkg::ADDR_BASE)
		else $error("device acked a foreign address");
	no_drive_a: assert property (rise_ev && !bit_q[3] && (first_q || !rd_q) |-> !sda_oe_s)
		else $error("device drove a master bit");
	wr_ack_a: assert property (ninth && !first_q && acked_q && !rd_q |-> sda_oe_s)
		else $error("written byte not acknowledged");
	rd_free_a: assert property (ninth && !first_q && rd_q |-> !sda_oe_s)
		else $error("device drove the master ack slot");
	stop_rel_a: assert property (stop_ev |-> !sda_oe_s [*8])
		else $error("device drives sda after stop");
	ack_end_a: assert property ($fell(scl) && $past(sda_oe_s) && !rd_q && bit_q == 4'h0 |-> ##[0:4] !sda_oe_s)
		else $error("ack held past its bit");
	rate_a: assert property (rise_ev |-> gap_q >= 11'(4 * rbs_pkg::QUARTER_CYC - 1))
		else $error("link clock rises faster than allowed");
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic       i_clk, i_rstn, i_strap_high, i_strap_low, i_stat_we, i_cmd_valid, i_cmd_read;
	logic [4:0] i_stat_idx;
	logic [6:0] i_cmd_dev, i_cmd_reg, own_addr, rnd_reg;
	logic [3:0] i_cmd_len;
	logic [7:0] i_stat_data, i_wdata, stat_v;
	logic [7:0] wbuf[4];
	logic [7:0] bank[128];
	logic [14:0] wq[$];
	logic [7:0] rq[$];
	int         widx, stops, bad_count, comparisons;
	wire        o_stat_ready, o_wr_valid, o_stop, o_cmd_ready, o_wdata_take;
	wire        o_rdata_valid, o_done, o_nack_err;
	wire  [6:0] o_wr_addr;
	wire  [7:0] o_wr_data, o_rdata;

	rbs_link_if link ();
	rbs_dev rbs_dev_i (.i_clk(i_clk), .i_rstn(i_rstn), .link(link),
		.i_strap_high(i_strap_high), .i_strap_low(i_strap_low), .i_stat_we(i_stat_we),
		.i_stat_idx(i_stat_idx), .i_stat_data(i_stat_data), .o_stat_ready(o_stat_ready),
		.o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .o_stop(o_stop));
	rbs_host rbs_host_i (.i_clk(i_clk), .i_rstn(i_rstn), .link(link),
		.i_cmd_valid(i_cmd_valid), .i_cmd_read(i_cmd_read), .i_cmd_dev(i_cmd_dev),
		.i_cmd_reg(i_cmd_reg), .i_cmd_len(i_cmd_len), .o_cmd_ready(o_cmd_ready),
		.i_wdata(i_wdata), .o_wdata_take(o_wdata_take), .o_rdata(o_rdata),
		.o_rdata_valid(o_rdata_valid), .o_done(o_done), .o_nack_err(o_nack_err));
	rbs_link_properties rbs_link_properties_i (.i_clk(i_clk), .i_rstn(i_rstn),
		.scl(link.scl), .sda(link.sda), .sda_oe_m(link.sda_oe_m), .sda_o_m(link.sda_o_m),
		.sda_oe_s(link.sda_oe_s), .sda_o_s(link.sda_o_s));

	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	// ********************************
	// monitors and checking
	// ********************************
	always @(posedge i_clk) begin
		if (o_wr_valid) wq.push_back({o_wr_addr, o_wr_data});
		if (o_rdata_valid) rq.push_back(o_rdata);
		if (o_stop) stops++;
		if (o_wdata_take) begin
			widx++;
			i_wdata <= wbuf[widx[1:0]];
		end
	end

	function automatic logic keeps(input logic [6:0] loc);
		return loc <= rbs_pkg::RW_LAST;
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// one whole frame; junk tries a status write while the bus is busy
	task automatic run(input logic rd, input logic [6:0] dev, input logic [6:0] rg,
		input logic [3:0] len, input logic junk);
		int         n;
		int         j;
		logic [6:0] loc;
		logic       ok;
		ok = (dev == own_addr);
		j = 0;
		stops = 0;
		widx = 0;
		wq.delete();
		rq.delete();
		foreach (wbuf[k]) wbuf[k] = 8'($urandom);
		@(posedge i_clk);
		i_cmd_valid <= 1'b1;
		i_cmd_read  <= rd;
		i_cmd_dev   <= dev;
		i_cmd_reg   <= rg;
		i_cmd_len   <= len;
		i_wdata     <= wbuf[0];
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_cmd_ready !== 1'b1 && n < 8);
		i_cmd_valid <= 1'b0;
		if (o_cmd_ready !== 1'b1) begin
			bad_count++;
			final_report();
		end
		if (junk) begin
			n = 0;
			while (o_stat_ready === 1'b1 && n < 2000) begin
				@(posedge i_clk);
				n++;
			end
			if (n >= 2000) begin
				bad_count++;
				final_report();
			end
			i_stat_we   <= 1'b1;
			i_stat_data <= ~stat_v;
			@(posedge i_clk);
			i_stat_we <= 1'b0;
		end
		n = 0;
		while (o_done !== 1'b1 && n < 400000) begin
			@(posedge i_clk);
			n++;
		end
		while (stops == 0 && n < 401000) begin
			@(posedge i_clk);
			n++;
		end
		if (n >= 400000) begin
			bad_count++;
			final_report();
		end
		check(8'(stops), 8'h01);
		check(8'(link.sda), 8'h01);
		check(8'(o_nack_err), 8'(!ok));
		for (int k = 0; k < len && ok; k++) begin
			loc = rg + 7'(k);
			if (rd) begin
				check(rq[k], bank[loc]);
			end else if (keeps(loc)) begin
				check({1'b0, wq[j][14:8]}, {1'b0, loc});
				check(wq[j][7:0], wbuf[k]);
				bank[loc] = wbuf[k];
				j++;
			end
		end
		check(8'(wq.size()), 8'(j));
		check(8'(rq.size()), (rd && ok) ? 8'(len) : 8'h00);
		$display("test %s from %h to %h done", rd ? "read" : "write", rg, dev);
	endtask

	// ********************************
	// main sequence
	// ********************************
	initial begin
		void'($urandom(32'h60e4f822));
		{i_strap_high, i_strap_low} = 2'($urandom);
		stat_v = 8'($urandom);
		rnd_reg = 7'($urandom_range(0, 125));
		i_rstn = 1'b0;
		i_stat_idx = 5'h1f;
		{i_stat_we, i_cmd_valid, i_cmd_read, i_cmd_dev, i_cmd_reg, i_cmd_len} = '0;
		{i_stat_data, i_wdata} = '0;
		bad_count = 0;
		comparisons = 0;
		foreach (bank[k]) bank[k] = 8'h00;
		own_addr = {rbs_pkg::ADDR_BASE, i_strap_high, i_strap_low};
		repeat (12) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (2) @(posedge i_clk);
		check(8'(o_stat_ready), 8'h01);
		i_stat_we   <= 1'b1;
		i_stat_data <= stat_v;
		bank[127] = stat_v;
		@(posedge i_clk);
		i_stat_we <= 1'b0;
		$display("test status load done");
		// across the end of the writable range, then wrapping past the top
		run(1'b0, own_addr, 7'h4f, 4'h3, 1'b0);
		run(1'b1, own_addr, 7'h4f, 4'h3, 1'b0);
		run(1'b0, own_addr, 7'h7f, 4'h2, 1'b1);
		run(1'b1, own_addr, 7'h7f, 4'h2, 1'b0);
		run(1'b0, own_addr, rnd_reg, 4'h2, 1'b0);
		run(1'b1, own_addr, rnd_reg, 4'h2, 1'b0);
		// one strap bit and two fixed bits wrong
		for (int k = 0; k < 3; k++) begin
			run(1'b0, own_addr ^ (7'h01 << (3 * k)), 7'h00, 4'h1, 1'b0);
		end
		final_report();
	end
endmodule
`default_nettype wire
